// ---- hdl/iod_pkg.sv ----
// iod_pkg: constants shared by the host I/O base address decoder.
// assumes a ten-bit host I/O address, an eight-bit data bus and eight locations per card.
package iod_pkg;

  // ==========================================================================
  // address layout
  localparam int ADDR_W   = 10;           // host I/O address width
  localparam int SW_W     = 7;            // base select switch positions
  localparam int OFF_W    = 3;            // offset bits inside the block
  localparam int DATA_W   = 8;            // host data width
  localparam int ADC_W    = 12;           // converter result width
  localparam int BASE_LSB = 3;            // lowest compared address bit

  // ==========================================================================
  // register offsets inside the decoded block
  localparam logic [2:0] OFF_ADC_LOW_AND_DIGITAL_OUT  = 3'h0;
  localparam logic [2:0] OFF_ADC_HIGH_AND_CONV_START  = 3'h1;
  localparam logic [2:0] OFF_STATUS_AND_CONTROL_ONE   = 3'h2;
  localparam logic [2:0] OFF_DIGITAL_IN_AND_CONTROL_TWO = 3'h3;
  localparam logic [2:0] OFF_COUNTER_ZERO_PORT        = 3'h4;
  localparam logic [2:0] OFF_COUNTER_ONE_PORT         = 3'h5;
  localparam logic [2:0] OFF_COUNTER_TWO_PORT         = 3'h6;
  localparam logic [2:0] OFF_COUNTER_CONTROL_PORT     = 3'h7;

  // counter index presented with a counter strobe; 3 addresses the control byte
  localparam logic [1:0] CNT_IDX_CONTROL = 2'h3;

  // ==========================================================================
  // values after reset
  localparam logic [7:0]  RST_DIG_OUT = 8'h00;
  localparam logic [3:0]  RST_NIBBLE  = 4'h0;
  localparam logic [11:0] RST_ADC     = 12'h000;
  localparam logic [7:0]  RST_BYTE    = 8'h00;

  // bus phase, one-hot
  typedef enum logic [2:0] {
    PH_IDLE  = 3'b001,
    PH_READ  = 3'b010,
    PH_WRITE = 3'b100
  } iod_phase_t;

endpackage

// ---- hdl/iod_sync.sv ----
// iod_sync: two-stage synchroniser for a vector of pin inputs.
// assumes each bit is a slow level; multi-bit words are only read while the bus strobe is stable.
`timescale 1ns/100ps
module iod_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ==========================================================================
  // first stage feeds only the second stage
  logic [W-1:0] meta_ff;  // metastable capture stage

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST_VAL;
      q       <= RST_VAL;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule

// ---- hdl/iod_top.sv ----
// iod_top: host I/O base address decoder and its eight-location register bank.
// assumes asynchronous host bus pins sampled on SYS_CLK; converter, counters and
// digital lines live outside and talk to this block on SYS_CLK.
//
// What this block does
// - compare A3..A9 against base select switch
// - A0..A2 pick one of eight locations
// - switch off needs one, on needs zero
// - switch position for A9 is MSB
// - offsets 4,5,6 reach the three counters
// - offset 0 reads ADC low, writes outputs
// - offset 1 reads ADC high, write starts
// - offset 2 reads status, writes control one
// - offset 3 reads inputs, writes control two
// - offset 7 writes counter control; read nothing
// - any write to offset 1 starts; busy until done
`timescale 1ns/100ps
module iod_top (
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic [9:0]  BUS_ADDR,
  input  wire logic        BUS_IOR_N,
  input  wire logic        BUS_IOW_N,
  input  wire logic        BUS_AEN,
  input  wire logic [7:0]  BUS_DATA_IN,
  output logic      [7:0]  BUS_DATA_OUT,
  output logic             BUS_DATA_OE,
  input  wire logic [6:0]  BASE_SELECT_SWITCH,
  input  wire logic [7:0]  DIG_IN,
  input  wire logic [11:0] ADC_RESULT,
  input  wire logic        ADC_DONE,
  input  wire logic        IRQ_EVENT,
  input  wire logic [7:0]  CNT_RDATA,
  output logic             CONV_START,
  output logic             CONV_BUSY,
  output logic [7:0]       DIG_OUT,
  output logic [3:0]       OP_OUT,
  output logic             IRQ_ENABLE,
  output logic [2:0]       MUX_SEL,
  output logic             USER_OUT,
  output logic [2:0]       GAIN_SEL,
  output logic             CNT_WR,
  output logic             CNT_RD,
  output logic [1:0]       CNT_INDEX,
  output logic [7:0]       CNT_WDATA
);

  // ==========================================================================
  // pin synchronisers
  localparam int SYNC_W = 3 + 10 + 8 + 7 + 8;
  localparam logic [SYNC_W-1:0] SYNC_RST = {3'b011, {(SYNC_W-3){1'b0}}};

  logic [SYNC_W-1:0] sync_q;   // synchronised pin vector
  logic              s_aen;    // dma owns the bus
  logic              s_ior_n;  // host read strobe
  logic              s_iow_n;  // host write strobe
  logic [9:0]        s_addr;   // host address
  logic [7:0]        s_data;   // host write data
  logic [6:0]        s_sw;     // switch setting, 1 = off
  logic [7:0]        s_din;    // digital input lines

  iod_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .d     ({BUS_AEN, BUS_IOR_N, BUS_IOW_N, BUS_ADDR, BUS_DATA_IN,
             BASE_SELECT_SWITCH, DIG_IN}),
    .q     (sync_q)
  );

  assign {s_aen, s_ior_n, s_iow_n, s_addr, s_data, s_sw, s_din} = sync_q;

  // ==========================================================================
  // address decode
  logic match;     // upper address hits the switch setting
  logic rd_req;    // qualified read cycle
  logic wr_req;    // qualified write cycle

  // off switch reads as one and demands a one; bit 6 sits against A9
  assign match  = (s_addr[9:iod_pkg::BASE_LSB] == s_sw);
  assign rd_req = match && !s_aen && !s_ior_n && s_iow_n;
  assign wr_req = match && !s_aen && !s_iow_n && s_ior_n;

  // ==========================================================================
  // bus phase machine
  iod_pkg::iod_phase_t phase_ff;  // current bus phase
  logic [2:0]          off_ff;    // offset latched at cycle start
  logic [7:0]          wdat_ff;   // write data held while strobe is low
  logic                rd_start;  // first cycle of a read
  logic                wr_commit; // trailing edge of a write

  assign rd_start  = (phase_ff == iod_pkg::PH_IDLE) && rd_req;
  assign wr_commit = (phase_ff == iod_pkg::PH_WRITE) && s_iow_n;

  // a cycle is owned from strobe fall to strobe rise, so address glitches later are ignored
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      phase_ff <= iod_pkg::PH_IDLE;
      off_ff   <= 3'h0;
    end else begin
      unique case (phase_ff)
        iod_pkg::PH_IDLE: begin
          if (rd_req) begin
            phase_ff <= iod_pkg::PH_READ;
            off_ff   <= s_addr[2:0];
          end else if (wr_req) begin
            phase_ff <= iod_pkg::PH_WRITE;
            off_ff   <= s_addr[2:0];
          end
        end
        iod_pkg::PH_READ: begin
          if (s_ior_n) phase_ff <= iod_pkg::PH_IDLE;
        end
        iod_pkg::PH_WRITE: begin
          if (s_iow_n) phase_ff <= iod_pkg::PH_IDLE;
        end
        default: phase_ff <= iod_pkg::PH_IDLE;
      endcase
    end
  end

  // write data is taken while the strobe is still low; host data may be late at the fall
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) wdat_ff <= iod_pkg::RST_BYTE;
    else if (!s_iow_n) wdat_ff <= s_data;
  end

  // ==========================================================================
  // register bank
  logic [7:0]  dout_ff;   // digital output register
  logic [3:0]  op_ff;     // shared output bits of both control registers
  logic [3:0]  ctl1_ff;   // interrupt enable and mux channel
  logic [3:0]  ctl2_ff;   // user bit and gain
  logic [11:0] adc_ff;    // last converter result
  logic        busy_ff;   // conversion in progress
  logic        irq_ff;    // interrupt seen
  logic        start_ff;  // conversion start pulse

  function automatic logic wr_at(input logic [2:0] off);
    wr_at = wr_commit && (off_ff == off);
  endfunction

  // control writes; op bits are reachable from either control location
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      dout_ff <= iod_pkg::RST_DIG_OUT;
      op_ff   <= iod_pkg::RST_NIBBLE;
      ctl1_ff <= iod_pkg::RST_NIBBLE;
      ctl2_ff <= iod_pkg::RST_NIBBLE;
    end else begin
      if (wr_at(iod_pkg::OFF_ADC_LOW_AND_DIGITAL_OUT)) dout_ff <= wdat_ff;
      if (wr_at(iod_pkg::OFF_STATUS_AND_CONTROL_ONE)) begin
        op_ff   <= wdat_ff[7:4];
        ctl1_ff <= wdat_ff[3:0];
      end
      if (wr_at(iod_pkg::OFF_DIGITAL_IN_AND_CONTROL_TWO)) begin
        op_ff   <= wdat_ff[7:4];
        ctl2_ff <= wdat_ff[3:0];
      end
    end
  end

  // conversion: data value is ignored; a start in the done cycle keeps busy set
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      start_ff <= 1'b0;
      busy_ff  <= 1'b0;
      adc_ff   <= iod_pkg::RST_ADC;
    end else begin
      start_ff <= wr_at(iod_pkg::OFF_ADC_HIGH_AND_CONV_START);
      if (ADC_DONE) adc_ff <= ADC_RESULT;
      if (wr_at(iod_pkg::OFF_ADC_HIGH_AND_CONV_START)) busy_ff <= 1'b1;
      else if (ADC_DONE) busy_ff <= 1'b0;
    end
  end

  // interrupt flag: event wins over a clear by control write or start
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) irq_ff <= 1'b0;
    else if (IRQ_EVENT) irq_ff <= 1'b1;
    else if (wr_at(iod_pkg::OFF_STATUS_AND_CONTROL_ONE) ||
             wr_at(iod_pkg::OFF_DIGITAL_IN_AND_CONTROL_TWO) ||
             start_ff) irq_ff <= 1'b0;
  end

  // ==========================================================================
  // counter ports: strobes are registered one clock before reaching the counter block
  logic       cwr_ff;   // counter write strobe
  logic       crd_ff;   // counter read strobe
  logic [1:0] cidx_ff;  // counter index
  logic [7:0] cdat_ff;  // counter write data

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cwr_ff  <= 1'b0;
      crd_ff  <= 1'b0;
      cidx_ff <= 2'h0;
      cdat_ff <= iod_pkg::RST_BYTE;
    end else begin
      cwr_ff <= wr_commit && off_ff[2];
      crd_ff <= rd_start && s_addr[2] && (s_addr[2:0] != iod_pkg::OFF_COUNTER_CONTROL_PORT);
      if (wr_commit && off_ff[2]) begin
        cidx_ff <= off_ff[1:0];
        cdat_ff <= wdat_ff;
      end else if (rd_start && s_addr[2]) begin
        cidx_ff <= s_addr[1:0];
      end
    end
  end

  // ==========================================================================
  // read path
  logic [7:0] rdat_ff;  // read data driven to the host
  logic       oe_ff;    // host data driver enable

  // read multiplexer; counter data is only current while the read stands
  function automatic logic [7:0] rd_mux(input logic [2:0] off);
    unique case (off)
      iod_pkg::OFF_ADC_LOW_AND_DIGITAL_OUT:    rd_mux = {adc_ff[3:0], op_ff};
      iod_pkg::OFF_ADC_HIGH_AND_CONV_START:    rd_mux = adc_ff[11:4];
      iod_pkg::OFF_STATUS_AND_CONTROL_ONE:     rd_mux = {busy_ff, ctl2_ff[2:0], irq_ff,
                                                         ctl1_ff[2:0]};
      iod_pkg::OFF_DIGITAL_IN_AND_CONTROL_TWO: rd_mux = s_din;
      iod_pkg::OFF_COUNTER_CONTROL_PORT:       rd_mux = iod_pkg::RST_BYTE;
      default:                                 rd_mux = CNT_RDATA;
    endcase
  endfunction

  // data is refreshed every cycle of the read so late counter answers still arrive
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdat_ff <= iod_pkg::RST_BYTE;
      oe_ff   <= 1'b0;
    end else if (rd_start) begin
      rdat_ff <= rd_mux(s_addr[2:0]);
      oe_ff   <= (s_addr[2:0] != iod_pkg::OFF_COUNTER_CONTROL_PORT);
    end else if (phase_ff == iod_pkg::PH_READ && !s_ior_n) begin
      rdat_ff <= rd_mux(off_ff);
    end else begin
      oe_ff   <= 1'b0;
    end
  end

  // ==========================================================================
  // outputs
  assign BUS_DATA_OUT = rdat_ff;
  assign BUS_DATA_OE  = oe_ff;
  assign CONV_START   = start_ff;
  assign CONV_BUSY    = busy_ff;
  assign DIG_OUT      = dout_ff;
  assign OP_OUT       = op_ff;
  assign IRQ_ENABLE   = ctl1_ff[3];
  assign MUX_SEL      = ctl1_ff[2:0];
  assign USER_OUT     = ctl2_ff[3];
  assign GAIN_SEL     = ctl2_ff[2:0];
  assign CNT_WR       = cwr_ff;
  assign CNT_RD       = crd_ff;
  assign CNT_INDEX    = cidx_ff;
  assign CNT_WDATA    = cdat_ff;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  a_no_match_idle: assert property (
    (phase_ff == iod_pkg::PH_IDLE) && (s_addr[9:3] != s_sw) |=> phase_ff == iod_pkg::PH_IDLE)
    else $error("decoder left idle without address match");
  a_dma_ignored: assert property (
    (phase_ff == iod_pkg::PH_IDLE) && s_aen |=> phase_ff == iod_pkg::PH_IDLE ##0 !oe_ff)
    else $error("decoder answered a dma cycle");
  a_offset_latch: assert property (
    rd_start || (phase_ff == iod_pkg::PH_IDLE && wr_req) |=> off_ff == $past(s_addr[2:0]))
    else $error("offset not taken from low address bits");
  a_dout_write: assert property (
    wr_commit && off_ff == iod_pkg::OFF_ADC_LOW_AND_DIGITAL_OUT |=> DIG_OUT == $past(wdat_ff))
    else $error("digital output not loaded");
  a_start_busy: assert property (
    wr_commit && off_ff == iod_pkg::OFF_ADC_HIGH_AND_CONV_START
      |=> CONV_START && CONV_BUSY ##1 !CONV_START)
    else $error("conversion start not a single pulse with busy");
  a_busy_hold: assert property (
    busy_ff && !ADC_DONE |=> busy_ff)
    else $error("busy dropped before converter finished");
  a_read_data: assert property (
    rd_start && s_addr[2:0] == iod_pkg::OFF_STATUS_AND_CONTROL_ONE |=> BUS_DATA_OE
      && BUS_DATA_OUT == {$past(CONV_BUSY), $past(GAIN_SEL), $past(irq_ff), $past(MUX_SEL)})
    else $error("status read data wrong at read start");
  a_read_drive: assert property (
    rd_start && s_addr[2:0] != iod_pkg::OFF_COUNTER_CONTROL_PORT |=> BUS_DATA_OE)
    else $error("matching read did not drive the bus");
  a_read_seven: assert property (
    rd_start && s_addr[2:0] == iod_pkg::OFF_COUNTER_CONTROL_PORT |=> !BUS_DATA_OE [*2])
    else $error("offset seven read drove the bus");
  a_counter_wr: assert property (
    wr_commit && off_ff[2] |=> CNT_WR && CNT_INDEX == $past(off_ff[1:0]))
    else $error("counter strobe or index wrong");
  a_ctl_write: assert property (
    wr_commit && off_ff == iod_pkg::OFF_DIGITAL_IN_AND_CONTROL_TWO
      |=> OP_OUT == $past(wdat_ff[7:4])
      && GAIN_SEL == $past(wdat_ff[2:0]))
    else $error("control two not loaded");

  c_read_status: cover property (rd_start && s_addr[2:0] == iod_pkg::OFF_STATUS_AND_CONTROL_ONE);
  c_conv_done:   cover property (CONV_BUSY ##[1:20] !CONV_BUSY);
  c_cnt_ctrl:    cover property (wr_commit && off_ff == iod_pkg::OFF_COUNTER_CONTROL_PORT);

endmodule

// ---- testbench/iod_host.sv ----
// iod_host: behavioural host processor on the expansion bus.
// assumes it is clocked by the system clock and driven only through its task.
`timescale 1ns/100ps
module iod_host (
  input  wire logic       clk,
  output logic      [9:0] addr,
  output logic            ior_n,
  output logic            iow_n,
  output logic            aen,
  output logic      [7:0] wdata,
  input  wire logic [7:0] rdata,
  input  wire logic       rd_oe
);
  // ==========================================================================
  // idle bus at time zero
  initial begin
    addr = 10'h000;
    ior_n = 1'b1;
    iow_n = 1'b1;
    aen = 1'b0;
    wdata = 8'h00;
  end

  // ==========================================================================
  // one i/o cycle; strobe low five clocks, high four, so the two-flop
  // sampling in the decoder always sees a clean edge on either side
  task automatic cycle(input logic wr, input logic [9:0] a, input logic [7:0] d,
                       input logic dma, output logic [7:0] q, output logic oe);
    @(negedge clk);
    addr = a;
    aen = dma;
    if (wr) begin
      wdata = d;
      iow_n = 1'b0;
    end else begin
      ior_n = 1'b0;
    end
    repeat (5) @(negedge clk);
    // answer taken while the strobe is still low
    q = rdata;
    oe = rd_oe;
    ior_n = 1'b1;
    iow_n = 1'b1;
    // released data lines must not keep showing the last byte
    wdata = ~wdata;
    repeat (4) @(negedge clk);
  endtask
endmodule

// ---- testbench/tb.sv ----
// tb: self-checking bench for the host base address decoder.
// assumes the host model drives the bus pins; the bench drives the rest.
`timescale 1ns/100ps
module tb;
  // ==========================================================================
  // clock, reset and pins
  logic        sys_clk = 1'b0;      // 100 MHz
  logic        resetn = 1'b0;       // held low for 8 cycles
  logic [9:0]  bus_addr;            // host address
  logic        ior_n, iow_n, aen;   // host strobes
  logic [7:0]  wdata, rdata;        // host data both ways
  logic        oe;                  // read drive enable
  logic [6:0]  sw = 7'h60;          // base 300 hex
  logic [7:0]  dig_in = 8'h00;      // digital lines
  logic [7:0]  cnt_rdata = 8'h00;   // counter read byte
  logic [11:0] adc_result = 12'h000; // converter result
  logic        adc_done = 1'b0;     // converter finished
  logic        irq_event = 1'b0;    // interrupt event
  logic        conv_start, conv_busy, irq_en, user_out, cnt_wr, cnt_rd;
  logic [7:0]  dig_out, cnt_wdata;
  logic [3:0]  op_out;
  logic [2:0]  mux_sel, gain_sel;
  logic [1:0]  cnt_index;
  int          fails = 0, num_checks = 0;
  int          n_start = 0, n_wr = 0, n_rd = 0; // strobe pulse counts
  logic [7:0]  q;
  logic        o;

  always #5 sys_clk = ~sys_clk;

  // count strobe pulses so single-cycle widths are checked too
  always @(posedge sys_clk) begin
    if (conv_start === 1'b1) n_start++;
    if (cnt_wr === 1'b1) n_wr++;
    if (cnt_rd === 1'b1) n_rd++;
  end

  iod_host iod_host_i (.clk(sys_clk), .addr(bus_addr), .ior_n(ior_n), .iow_n(iow_n),
    .aen(aen), .wdata(wdata), .rdata(rdata), .rd_oe(oe));

  iod_top iod_top_i (.SYS_CLK(sys_clk), .RESETN(resetn), .BUS_ADDR(bus_addr),
    .BUS_IOR_N(ior_n), .BUS_IOW_N(iow_n), .BUS_AEN(aen), .BUS_DATA_IN(wdata),
    .BUS_DATA_OUT(rdata), .BUS_DATA_OE(oe), .BASE_SELECT_SWITCH(sw), .DIG_IN(dig_in),
    .ADC_RESULT(adc_result), .ADC_DONE(adc_done), .IRQ_EVENT(irq_event),
    .CNT_RDATA(cnt_rdata), .CONV_START(conv_start), .CONV_BUSY(conv_busy),
    .DIG_OUT(dig_out), .OP_OUT(op_out), .IRQ_ENABLE(irq_en), .MUX_SEL(mux_sel),
    .USER_OUT(user_out), .GAIN_SEL(gain_sel), .CNT_WR(cnt_wr), .CNT_RD(cnt_rd),
    .CNT_INDEX(cnt_index), .CNT_WDATA(cnt_wdata));

  // ==========================================================================
  // helpers
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic dma);
    iod_host_i.cycle(1'b1, a, d, dma, q, o);
  endtask

  // read; data only judged when the card should drive the bus
  task automatic rd(input logic [9:0] a, input logic [7:0] exp, input logic eoe);
    iod_host_i.cycle(1'b0, a, 8'h00, 1'b0, q, o);
    chk({11'h000, o}, {11'h000, eoe});
    if (eoe) chk({4'h0, q}, {4'h0, exp});
  endtask

  task automatic give_verdict;
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_decode;
    wr(10'h300, 8'ha5, 1'b0); chk(12'(dig_out), 12'h0a5);
    wr(10'h308, 8'h3c, 1'b0); chk(12'(dig_out), 12'h0a5);
    wr(10'h100, 8'h3c, 1'b0); chk(12'(dig_out), 12'h0a5);
    wr(10'h300, 8'h3c, 1'b1); chk(12'(dig_out), 12'h0a5);
    sw = 7'h5f; // base 2f8, still on an eight-byte boundary in range
    wr(10'h2f8, 8'h5a, 1'b0); chk(12'(dig_out), 12'h05a);
    wr(10'h300, 8'h3c, 1'b0); chk(12'(dig_out), 12'h05a);
    sw = 7'h60;
  endtask

  task automatic t_ctrl;
    wr(10'h302, 8'h5b, 1'b0); chk({4'h0, op_out, irq_en, mux_sel}, 12'h05b);
    wr(10'h303, 8'hac, 1'b0); chk({4'h0, op_out, user_out, gain_sel}, 12'h0ac);
    @(negedge sys_clk) irq_event = 1'b1;
    @(negedge sys_clk) irq_event = 1'b0;
    rd(10'h302, 8'h4b, 1'b1);
    wr(10'h303, 8'hac, 1'b0); // control write clears the event flag
    rd(10'h302, 8'h43, 1'b1);
    rd(10'h300, 8'h0a, 1'b1);
    dig_in = 8'h96;
    rd(10'h303, 8'h96, 1'b1);
  endtask

  task automatic t_conv;
    int s;
    s = n_start;
    wr(10'h301, 8'hff, 1'b0); chk(12'(n_start - s), 12'h001);
    chk({11'h000, conv_busy}, 12'h001);
    rd(10'h302, 8'hc3, 1'b1);
    adc_result = 12'h9c7;
    @(negedge sys_clk) adc_done = 1'b1;
    @(negedge sys_clk) adc_done = 1'b0;
    chk({11'h000, conv_busy}, 12'h000);
    rd(10'h300, 8'h7a, 1'b1);
    rd(10'h301, 8'h9c, 1'b1);
  endtask

  task automatic t_counters;
    int s;
    for (int k = 4; k < 8; k++) begin
      s = n_wr;
      wr(10'(10'h300 + k), 8'(8'h10 + k), 1'b0);
      chk(12'(n_wr - s), 12'h001);
      chk(12'(cnt_index), 12'(k - 4));
      chk(12'(cnt_wdata), 12'(8'h10 + k));
    end
    for (int k = 4; k < 7; k++) begin
      cnt_rdata = 8'(8'h30 + k);
      s = n_rd;
      rd(10'(10'h300 + k), 8'(8'h30 + k), 1'b1);
      chk(12'(n_rd - s), 12'h001);
    end
    s = n_rd;
    rd(10'h307, 8'h00, 1'b0);
    chk(12'(n_rd - s), 12'h000);
  endtask

  // ==========================================================================
  // main sequence; outputs must be quiet while reset is held
  initial begin
    repeat (8) @(negedge sys_clk);
    chk({dig_out, op_out}, 12'h000);
    chk({7'h00, conv_start, conv_busy, cnt_wr, cnt_rd, oe}, 12'h000);
    resetn = 1'b1;
    repeat (2) @(negedge sys_clk);
    t_decode();
    t_ctrl();
    t_conv();
    t_counters();
    give_verdict();
  end

  // watchdog: the whole run needs well under 1000 clocks
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
endmodule
